// >>> hdl/modem_cfg.svh
`ifndef MODEM_CFG_SVH
`define MODEM_CFG_SVH

`define CLK_HZ          100000000
`define BIT_RATE_HZ     1200
`define BIT_DIV_CYCLES  (`CLK_HZ / `BIT_RATE_HZ)

`define ADDR_GEN_RESET  8'h01
`define ADDR_SETUP      8'he0
`define ADDR_TONES      8'he1
`define ADDR_TX_DATA    8'he3
`define ADDR_RX_DATA    8'he5
`define ADDR_STATUS     8'he6

`define SETUP_RESERVED  7
`define SETUP_LOOP_HI   3
`define SETUP_LOOP_LO   2
`define SETUP_CLK_HI    1
`define SETUP_CLK_LO    0

`define TONE_RESERVED   7
`define TONE_ON         6
`define TONE_TYPE       5
`define TONE_SINGLE     4
`define TONE_CODE_HI    3
`define TONE_CODE_LO    0

`define STAT_RX_READY   0
`define STAT_TX_READY   1
`define STAT_SLEEP      2

`define SETUP_RESET     8'h00
`define TONES_RESET     8'h00

`define F_NONE   12'd0
`define F_550    12'd550
`define F_697    12'd697
`define F_770    12'd770
`define F_852    12'd852
`define F_941    12'd941
`define F_1209   12'd1209
`define F_1300   12'd1300
`define F_1336   12'd1336
`define F_1477   12'd1477
`define F_1633   12'd1633
`define F_1800   12'd1800
`define F_2100   12'd2100
`define F_2225   12'd2225

`endif

// >>> hdl/modem_pkg.sv
package modem_pkg;
  typedef enum logic [1:0] {
    LOOP_NONE,
    LOOP_ANALOG,
    LOOP_LOCAL_DIG,
    LOOP_REMOTE_DIG
  } loop_mode_t;

  typedef enum logic [1:0] {
    BUS_ADDR,
    BUS_WRITE,
    BUS_READ,
    BUS_IGNORE
  } bus_state_t;
endpackage

// >>> hdl/modem_test_clock_tone_control.sv
// Behaviour
// R1: loopback field 00 keeps every signal path normal, no loopback.
// R2: code 01 feeds transmit gain output to receive gain input, opens receive op-amp.
// R3: code 10 shifts written transmit bytes at bit rate into receive buffer, flags full.
// R4: code 11 retimes demodulated bits and sends them through the transmit path.
// R5: clock field 01, 10, 11 select 3.6864, 7.3728, 11.0592 MHz dividers.
// R6: clock field 00 sleeps: all but bus and ring detector off, oscillator, bias off.
// R7: host waits at least 20 ms after leaving sleep before other commands.
// R8: host writes zero to the top bit of the tone register.
// R9: tone-on one outputs the tone; zero leaves output at bias.
// R10: host sets code and type first, then tone-on; clears tone-on to stop.
// R11: tone type one gives keypad dual tones, zero gives progress tones.
// R12: single-tone bit zero gives dual tones, one gives a single test tone.
// R13: keypad code picks one low and one high group frequency per the key table.
// R14: single-tone codes 0-7 give the high tone, 8-15 the low tone.
// R15: progress codes 0-4 give 550, 1300, 1800, 2100, 2225 Hz.
`timescale 1ns/1ns
`include "modem_cfg.svh"
module modem_test_clock_tone_control #(
  parameter int BIT_DIV = `BIT_DIV_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       cbus_csn_in,
  input  wire logic       cbus_sclk_in,
  input  wire logic       cbus_cmd_in,
  output logic            cbus_reply_out,
  output logic            cbus_reply_oe_out,
  input  wire logic       rx_demod_bit_in,
  input  wire logic       rx_demod_strobe_in,
  output logic            tx_mod_bit_out,
  output logic            tx_mod_strobe_out,
  output logic            analog_loop_out,
  output logic            rx_opamp_disconnect_out,
  output logic            remote_loop_out,
  output logic [1:0]      clock_divider_ratio_out,
  output logic            deep_sleep_out,
  output logic            osc_enable_out,
  output logic            bias_connect_out,
  output logic            tone_on_out,
  output logic            tone_low_out,
  output logic            tone_high_out
);
  logic [2:0]              csn_s;
  logic [2:0]              sclk_s;
  logic [2:0]              cmd_s;
  logic                    csn_q;
  logic                    sclk_q;
  logic                    sclk_rise;
  logic                    sclk_fall;
  modem_pkg::bus_state_t   bus_state;
  logic [7:0]              shift_in;
  logic [2:0]              bit_cnt;
  logic [7:0]              wr_addr;
  logic [7:0]              reply_sh;
  logic                    read_first;
  logic [7:0]              next_byte;
  logic                    wr_strobe;
  logic                    gen_reset;
  logic                    rx_read;
  logic [7:0]              setup;
  logic [7:0]              tones;
  logic [7:0]              tx_hold;
  logic                    tx_hold_full;
  logic [7:0]              tx_shift;
  logic [3:0]              tx_cnt;
  logic [7:0]              rx_shift;
  logic [2:0]              rx_cnt;
  logic [7:0]              rx_byte;
  logic                    rx_ready;
  logic                    remote_bit;
  logic [$clog2(BIT_DIV)-1:0] div_cnt;
  logic                    bit_tick;
  logic                    sleep;
  modem_pkg::loop_mode_t   loop_mode;
  logic                    ser_valid;
  logic                    rx_bit_en;
  logic                    rx_bit;
  logic [3:0]              code;
  logic [11:0]             low_freq;
  logic [11:0]             high_freq;

  // pin inputs: three flops; select and clock levels count once stages two and three agree, command is taken from stage three
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      csn_s  <= 3'h7;
      sclk_s <= 3'h0;
      cmd_s  <= 3'h0;
      csn_q  <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      csn_s  <= {csn_s[1:0], cbus_csn_in};
      sclk_s <= {sclk_s[1:0], cbus_sclk_in};
      cmd_s  <= {cmd_s[1:0], cbus_cmd_in};
      if (csn_s[1] == csn_s[2]) begin
        csn_q <= csn_s[2];
      end
      if (sclk_s[1] == sclk_s[2]) begin
        sclk_q <= sclk_s[2];
      end
    end
  end

  assign sclk_rise = (sclk_s[1] == sclk_s[2]) && sclk_s[2] && !sclk_q && !csn_q;
  assign sclk_fall = (sclk_s[1] == sclk_s[2]) && !sclk_s[2] && sclk_q && !csn_q;
  assign next_byte = {shift_in[6:0], cmd_s[2]};

  // serial control bus: one address byte, then one byte written or read
  always_ff @(posedge clk_in) begin
    if (srst_in || csn_q) begin
      bus_state  <= modem_pkg::BUS_ADDR;
      bit_cnt    <= 3'h0;
      shift_in   <= 8'h00;
      wr_addr    <= 8'h00;
      reply_sh   <= 8'h00;
      read_first <= 1'b0;
      wr_strobe  <= 1'b0;
      gen_reset  <= 1'b0;
      rx_read    <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      gen_reset <= 1'b0;
      rx_read   <= 1'b0;
      if (sclk_rise) begin
        shift_in <= next_byte;
        bit_cnt  <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          case (bus_state)
            modem_pkg::BUS_ADDR: begin
              wr_addr <= next_byte;
              case (next_byte)
                `ADDR_GEN_RESET: begin
                  gen_reset <= 1'b1;
                  bus_state <= modem_pkg::BUS_IGNORE;
                end
                `ADDR_SETUP, `ADDR_TONES, `ADDR_TX_DATA: begin
                  bus_state <= modem_pkg::BUS_WRITE;
                end
                `ADDR_RX_DATA: begin
                  reply_sh   <= rx_byte;
                  rx_read    <= 1'b1;
                  read_first <= 1'b1;
                  bus_state  <= modem_pkg::BUS_READ;
                end
                `ADDR_STATUS: begin
                  reply_sh   <= {5'h00, sleep, ~tx_hold_full, rx_ready};
                  read_first <= 1'b1;
                  bus_state  <= modem_pkg::BUS_READ;
                end
                default: begin
                  bus_state <= modem_pkg::BUS_IGNORE;
                end
              endcase
            end
            modem_pkg::BUS_WRITE: begin
              wr_strobe <= 1'b1;
              bus_state <= modem_pkg::BUS_IGNORE;
            end
            modem_pkg::BUS_READ: begin
              // last reply bit must still stand while its clock is high
              bus_state <= modem_pkg::BUS_READ;
            end
            default: begin
              bus_state <= modem_pkg::BUS_IGNORE;
            end
          endcase
        end
      end
      // reply bit changes on the falling clock so it is stable while clock is high
      if (sclk_fall && bus_state == modem_pkg::BUS_READ) begin
        if (read_first) begin
          read_first <= 1'b0;
        end else begin
          reply_sh <= {reply_sh[6:0], 1'b0};
        end
      end
    end
  end

  assign cbus_reply_out    = reply_sh[7];
  assign cbus_reply_oe_out = (bus_state == modem_pkg::BUS_READ) && !csn_q;

  // write-only control registers; the bus stays alive in sleep
  always_ff @(posedge clk_in) begin
    if (srst_in || gen_reset) begin
      setup <= `SETUP_RESET;
      tones <= `TONES_RESET;
    end else if (wr_strobe) begin
      if (wr_addr == `ADDR_SETUP) begin
        setup <= shift_in;
      end
      if (wr_addr == `ADDR_TONES) begin
        tones <= shift_in;
      end
    end
  end

  assign sleep = (setup[`SETUP_CLK_HI:`SETUP_CLK_LO] == 2'b00); // R6

  always_comb begin
    case (setup[`SETUP_LOOP_HI:`SETUP_LOOP_LO])
      2'b01:   loop_mode = modem_pkg::LOOP_ANALOG;
      2'b10:   loop_mode = modem_pkg::LOOP_LOCAL_DIG;
      2'b11:   loop_mode = modem_pkg::LOOP_REMOTE_DIG;
      default: loop_mode = modem_pkg::LOOP_NONE; // R1
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      analog_loop_out         <= 1'b0;
      rx_opamp_disconnect_out <= 1'b0;
      remote_loop_out         <= 1'b0;
      clock_divider_ratio_out <= 2'b00;
      deep_sleep_out          <= 1'b1;
      osc_enable_out          <= 1'b0;
      bias_connect_out        <= 1'b0;
    end else begin
      analog_loop_out         <= !sleep && loop_mode == modem_pkg::LOOP_ANALOG; // R2
      rx_opamp_disconnect_out <= !sleep && loop_mode == modem_pkg::LOOP_ANALOG; // R2
      remote_loop_out         <= !sleep && loop_mode == modem_pkg::LOOP_REMOTE_DIG; // R4
      clock_divider_ratio_out <= setup[`SETUP_CLK_HI:`SETUP_CLK_LO]; // R5
      deep_sleep_out          <= sleep; // R6
      osc_enable_out          <= !sleep; // R6
      bias_connect_out        <= !sleep; // R6
    end
  end

  // bit-rate enable; held still in sleep since the oscillator is stopped
  always_ff @(posedge clk_in) begin
    if (srst_in || sleep) begin
      div_cnt <= '0;
    end else if (div_cnt == ($clog2(BIT_DIV))'(BIT_DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  assign bit_tick  = !sleep && (div_cnt == ($clog2(BIT_DIV))'(BIT_DIV - 1));
  assign ser_valid = bit_tick && (tx_cnt != 4'h0);

  // double-buffered transmit byte, sent msb first at the bit rate
  always_ff @(posedge clk_in) begin
    if (srst_in || gen_reset) begin
      tx_hold      <= 8'h00;
      tx_hold_full <= 1'b0;
      tx_shift     <= 8'h00;
      tx_cnt       <= 4'h0;
    end else begin
      if (bit_tick && tx_cnt == 4'h0 && tx_hold_full) begin
        tx_shift     <= tx_hold;
        tx_cnt       <= 4'h8;
        tx_hold_full <= 1'b0;
      end else if (ser_valid) begin
        tx_shift <= {tx_shift[6:0], 1'b0};
        tx_cnt   <= tx_cnt - 4'h1;
      end
      if (wr_strobe && wr_addr == `ADDR_TX_DATA) begin
        tx_hold      <= shift_in;
        tx_hold_full <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      remote_bit <= 1'b0;
    end else if (rx_demod_strobe_in) begin
      remote_bit <= rx_demod_bit_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tx_mod_bit_out    <= 1'b0;
      tx_mod_strobe_out <= 1'b0;
    end else if (loop_mode == modem_pkg::LOOP_REMOTE_DIG) begin
      tx_mod_bit_out    <= remote_bit; // R4
      tx_mod_strobe_out <= bit_tick; // R4
    end else begin
      tx_mod_bit_out    <= ser_valid ? tx_shift[7] : tx_mod_bit_out;
      tx_mod_strobe_out <= ser_valid && loop_mode != modem_pkg::LOOP_LOCAL_DIG;
    end
  end

  // local digital loop takes the serialiser, otherwise the demodulator feeds the buffer
  assign rx_bit_en = (loop_mode == modem_pkg::LOOP_LOCAL_DIG) ? ser_valid : // R3
                     (!sleep && rx_demod_strobe_in);
  assign rx_bit    = (loop_mode == modem_pkg::LOOP_LOCAL_DIG) ? tx_shift[7] : rx_demod_bit_in;

  always_ff @(posedge clk_in) begin
    if (srst_in || gen_reset) begin
      rx_shift <= 8'h00;
      rx_cnt   <= 3'h0;
      rx_byte  <= 8'h00;
      rx_ready <= 1'b0;
    end else begin
      if (rx_read) begin
        rx_ready <= 1'b0;
      end
      if (rx_bit_en) begin
        rx_shift <= {rx_shift[6:0], rx_bit};
        rx_cnt   <= rx_cnt + 3'h1;
        if (rx_cnt == 3'h7) begin
          rx_byte  <= {rx_shift[6:0], rx_bit}; // R3
          rx_ready <= 1'b1; // R3
        end
      end
    end
  end

  assign code = tones[`TONE_CODE_HI:`TONE_CODE_LO];

  function automatic logic [11:0] dtmf_low(input logic [3:0] c);
    case (c)
      4'h1, 4'h2, 4'h3, 4'hd: dtmf_low = `F_697;
      4'h4, 4'h5, 4'h6, 4'he: dtmf_low = `F_770;
      4'h7, 4'h8, 4'h9, 4'hf: dtmf_low = `F_852;
      default:                dtmf_low = `F_941;
    endcase
  endfunction

  function automatic logic [11:0] dtmf_high(input logic [3:0] c);
    case (c)
      4'h1, 4'h4, 4'h7, 4'hb: dtmf_high = `F_1209;
      4'h2, 4'h5, 4'h8, 4'ha: dtmf_high = `F_1336;
      4'h3, 4'h6, 4'h9, 4'hc: dtmf_high = `F_1477;
      default:                dtmf_high = `F_1633;
    endcase
  endfunction

  function automatic logic [11:0] progress_freq(input logic [3:0] c);
    case (c)
      4'h0:    progress_freq = `F_550;
      4'h1:    progress_freq = `F_1300;
      4'h2:    progress_freq = `F_1800;
      4'h3:    progress_freq = `F_2100;
      4'h4:    progress_freq = `F_2225;
      default: progress_freq = `F_NONE;
    endcase
  endfunction

  // codes without a defined progress tone give silence rather than a guess
  always_comb begin
    low_freq  = `F_NONE;
    high_freq = `F_NONE;
    if (!tones[`TONE_TYPE]) begin
      low_freq = progress_freq(code); // R11 R15
    end else if (!tones[`TONE_SINGLE]) begin
      low_freq  = dtmf_low(code); // R12 R13
      high_freq = dtmf_high(code); // R13
    end else if (!code[3]) begin
      high_freq = dtmf_high(code); // R14
    end else begin
      low_freq = dtmf_low(code); // R14
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tone_on_out <= 1'b0;
    end else begin
      tone_on_out <= tones[`TONE_ON] && !sleep; // R9
    end
  end

  tone_nco #(
    .CLK_HZ (`CLK_HZ)
  ) u_low_tone (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .enable_in  (tone_on_out && low_freq != `F_NONE), // R9
    .freq_hz_in (low_freq),
    .wave_out   (tone_low_out)
  );

  tone_nco #(
    .CLK_HZ (`CLK_HZ)
  ) u_high_tone (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .enable_in  (tone_on_out && high_freq != `F_NONE), // R9
    .freq_hz_in (high_freq),
    .wave_out   (tone_high_out)
  );
endmodule

// >>> hdl/tone_nco.sv
`timescale 1ns/1ns
module tone_nco #(
  parameter int CLK_HZ = 100000000
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        enable_in,
  input  wire logic [11:0] freq_hz_in,
  output logic             wave_out
);
  localparam logic [26:0] MOD  = 27'(CLK_HZ);
  localparam logic [26:0] HALF = 27'(CLK_HZ / 2);

  logic [26:0] acc;
  logic [26:0] next_acc;

  // modulo-clock accumulator gives exact frequency with no divider
  always_comb begin
    next_acc = acc + 27'(freq_hz_in);
    if (next_acc >= MOD) begin
      next_acc = next_acc - MOD;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || !enable_in) begin
      acc      <= 27'h0;
      wave_out <= 1'b0;
    end else begin
      acc      <= next_acc;
      wave_out <= (acc >= HALF);
    end
  end
endmodule

// >>> tb/modem_ctrl_chk.sv
`timescale 1ns/1ns
module modem_ctrl_chk (
  input logic       clk_in,
  input logic       srst_in,
  input logic       rx_demod_bit_in,
  input logic       rx_demod_strobe_in,
  input logic       tx_mod_bit_out,
  input logic       tx_mod_strobe_out,
  input logic       analog_loop_out,
  input logic       rx_opamp_disconnect_out,
  input logic       remote_loop_out,
  input logic [1:0] clock_divider_ratio_out,
  input logic       deep_sleep_out,
  input logic       osc_enable_out,
  input logic       bias_connect_out,
  input logic       tone_on_out,
  input logic       tone_low_out,
  input logic       tone_high_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic       held;
  logic [1:0] quiet;
  // the resent bit is judged only once the latched bit has settled for three cycles
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      held  <= 1'b0;
      quiet <= 2'd0;
    end else if (rx_demod_strobe_in) begin
      held  <= rx_demod_bit_in;
      quiet <= 2'd0;
    end else if (quiet != 2'd3) begin
      quiet <= quiet + 2'd1;
    end
  end
  a_sleep_power: assert property (deep_sleep_out |-> !osc_enable_out && !bias_connect_out)
    else $error("oscillator or bias on in sleep");
  a_awake_power: assert property (!deep_sleep_out |-> osc_enable_out && bias_connect_out)
    else $error("oscillator or bias off while awake");
  a_sleep_code: assert property (deep_sleep_out == (clock_divider_ratio_out == 2'b00))
    else $error("sleep flag disagrees with divider code");
  a_analog_route: assert property (analog_loop_out == rx_opamp_disconnect_out)
    else $error("analog loop and op-amp break differ");
  a_loop_exclusive: assert property (!(analog_loop_out && remote_loop_out))
    else $error("two loopbacks at once");
  a_sleep_mute: assert property (deep_sleep_out && $past(deep_sleep_out) |-> !tone_on_out)
    else $error("tone on during sleep");
  a_tone_quiet: assert property (!tone_on_out && !$past(tone_on_out) |->
    !tone_low_out && !tone_high_out)
    else $error("wave present with tone off");
  a_strobe_pulse: assert property (tx_mod_strobe_out |=> !tx_mod_strobe_out)
    else $error("modulator strobe longer than one cycle");
  a_reset_sleep: assert property ($fell(srst_in) |-> deep_sleep_out && !tone_on_out)
    else $error("not asleep after reset");
  a_remote_retime: assert property (remote_loop_out && tx_mod_strobe_out && quiet == 2'd3
    |-> tx_mod_bit_out == held)
    else $error("remote loop resent wrong bit");
  c_remote: cover property (remote_loop_out && tx_mod_strobe_out);
  c_analog: cover property (analog_loop_out);
  c_high: cover property ($rose(tone_high_out));
  c_wake: cover property ($fell(deep_sleep_out));
endmodule

// >>> tb/modem_host.sv
`timescale 1ns/1ns
module modem_host #(
  parameter int PHASE       = 6,
  parameter int WAKE_CYCLES = 200
) (
  input  logic       clk_in,
  input  logic       reply_in,
  input  logic       reply_oe_in,
  output logic       csn_out,
  output logic       sclk_out,
  output logic       cmd_out,
  output logic       rd_done_out,
  output logic [7:0] rd_q_out
);
  logic [1:0] clk_field;
  initial begin
    csn_out     = 1'b1;
    sclk_out    = 1'b0;
    cmd_out     = 1'b0;
    rd_done_out = 1'b0;
    rd_q_out    = 8'h00;
    clk_field   = 2'b00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // bits move only while the serial clock is low; an undriven reply reads as unknown
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd, input int n);
    logic [15:0] sh;
    sh = {a, d};
    csn_out = 1'b0;
    step(PHASE);
    for (int i = 0; i < n; i++) begin
      cmd_out = (rd && i > 7) ? ~cmd_out : sh[15-i];
      step(PHASE);
      sclk_out = 1'b1;
      step(PHASE);
      if (rd && i > 7) rd_q_out[15-i] = reply_oe_in ? reply_in : 1'bx;
      sclk_out = 1'b0;
    end
    step(PHASE);
    csn_out = 1'b1;
    cmd_out = ~cmd_out;
    step(PHASE);
    if (rd) begin
      rd_done_out = 1'b1;
      step(1);
      rd_done_out = 1'b0;
    end
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    xfer(a, d, 1'b0, 16);
  endtask
  task automatic read_reg(input logic [7:0] a);
    xfer(a, 8'h00, 1'b1, 16);
  endtask
  // the wake wait is shortened from its real length to keep runs short
  task automatic setup(input logic [1:0] loop, input logic [1:0] ck);
    write_reg(8'he0, {4'h0, loop, ck});
    if (clk_field == 2'b00 && ck != 2'b00) step(WAKE_CYCLES);
    clk_field = ck;
  endtask
  task automatic tone(input logic on, input logic dual, input logic sngl, input logic [3:0] c);
    write_reg(8'he1, {2'b00, dual, sngl, c});
    if (on) write_reg(8'he1, {2'b01, dual, sngl, c});
  endtask
  task automatic general_reset();
    xfer(8'h01, 8'h00, 1'b0, 8);
    clk_field = 2'b00;
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
  localparam int BIT_DIV = 16;
  logic        clk_in, srst_in, csn, sclk, cmd, reply, reply_oe, demod_bit, demod_stb;
  logic        tx_bit, tx_stb, analog, opamp, remote, sleep, osc, bias, tone_on, tlow, thigh;
  logic        rd_done, probe, chk_tx;
  logic [1:0]  ratio;
  logic [7:0]  rd_q, d;
  logic [10:0] q[$];
  integer      seed;
  int          failures, compares;
  wire  [10:0] stat = {analog, opamp, remote, ratio, sleep, osc, bias, tone_on, tlow, thigh};
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  modem_test_clock_tone_control #(.BIT_DIV(BIT_DIV)) dut_u (
    .clk_in(clk_in), .srst_in(srst_in), .cbus_csn_in(csn), .cbus_sclk_in(sclk),
    .cbus_cmd_in(cmd), .cbus_reply_out(reply), .cbus_reply_oe_out(reply_oe),
    .rx_demod_bit_in(demod_bit), .rx_demod_strobe_in(demod_stb), .tx_mod_bit_out(tx_bit),
    .tx_mod_strobe_out(tx_stb), .analog_loop_out(analog), .rx_opamp_disconnect_out(opamp),
    .remote_loop_out(remote), .clock_divider_ratio_out(ratio), .deep_sleep_out(sleep),
    .osc_enable_out(osc), .bias_connect_out(bias), .tone_on_out(tone_on),
    .tone_low_out(tlow), .tone_high_out(thigh));
  modem_host host_u (.clk_in(clk_in), .reply_in(reply), .reply_oe_in(reply_oe), .csn_out(csn),
    .sclk_out(sclk), .cmd_out(cmd), .rd_done_out(rd_done), .rd_q_out(rd_q));
  task report_and_stop();
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cmp(input logic [10:0] act);
    logic [10:0] e;
    compares++;
    e = (q.size() > 0) ? q.pop_front() : 11'bx;
    if (act !== e) begin
      failures++;
      $display("mismatch at %0t: expected %h got %h", $time, e, act);
    end
  endtask
  always @(posedge clk_in) begin
    if (probe) cmp(stat);
    if (rd_done) cmp({3'h0, rd_q});
    if (chk_tx && tx_stb) cmp({10'h0, tx_bit});
  end
  task step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task look(input logic [10:0] e);
    q.push_back(e);
    probe = 1'b1;
    step(1);
    probe = 1'b0;
  endtask
  // 0 picks the modulator strobe, 1 the high-group wave, 2 the low-group wave
  function automatic logic pick(input int w);
    pick = (w == 0) ? tx_stb : (w == 1) ? thigh : tlow;
  endfunction
  task automatic wait_sig(input int w, input int lim);
    int n;
    n = 0;
    @(posedge clk_in);
    while (pick(w) !== 1'b1) begin
      n++;
      if (n > lim) begin
        failures++;
        $display("mismatch at %0t: expected %h got %h", $time, 1'b1, pick(w));
        report_and_stop();
      end
      @(posedge clk_in);
    end
    #1;
  endtask
  initial begin
    srst_in = 1'b1;
    demod_bit = 1'b0;
    demod_stb = 1'b0;
    probe = 1'b0;
    chk_tx = 1'b0;
    failures = 0;
    compares = 0;
    seed = 32'hda4bab9f;
    step(12);
    srst_in = 1'b0;
    step(4);
    look(11'h020);
    for (int c = 1; c < 4; c++) begin
      host_u.setup(2'b00, 2'(c));
      look({3'b000, 2'(c), 6'b011000});
    end
    for (int l = 0; l < 4; l++) begin
      host_u.setup(2'(l), 2'b10);
      look({l == 1, l == 1, l == 3, 2'b10, 6'b011000});
    end
    host_u.setup(2'b10, 2'b10);
    for (int i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      host_u.write_reg(8'he3, d);
      step(12 * BIT_DIV);
      q.push_back(11'h003);
      host_u.read_reg(8'he6);
      q.push_back({3'h0, d});
      host_u.read_reg(8'he5);
      q.push_back(11'h002);
      host_u.read_reg(8'he6);
    end
    host_u.setup(2'b11, 2'b01);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      demod_bit = d[0];
      demod_stb = 1'b1;
      step(1);
      demod_stb = 1'b0;
      demod_bit = ~d[0];
      step(3);
      q.push_back({10'h0, d[0]});
      chk_tx = 1'b1;
      wait_sig(0, 4 * BIT_DIV);
      chk_tx = 1'b0;
    end
    host_u.setup(2'b00, 2'b01);
    host_u.tone(1'b1, 1'b1, 1'b1, 4'h0);
    wait_sig(1, 32000);
    look({5'b00001, 6'b011101});
    host_u.tone(1'b1, 1'b0, 1'b0, 4'h4);
    wait_sig(2, 24000);
    look({5'b00001, 6'b011110});
    host_u.tone(1'b0, 1'b0, 1'b0, 4'h4);
    look({5'b00001, 6'b011000});
    host_u.tone(1'b1, 1'b1, 1'b0, 4'hf);
    wait_sig(1, 32000);
    look({5'b00001, 6'b011101});
    host_u.setup(2'b00, 2'b00);
    look(11'h020);
    host_u.setup(2'b01, 2'b11);
    host_u.general_reset();
    look(11'h020);
    report_and_stop();
  end
endmodule
bind modem_test_clock_tone_control modem_ctrl_chk chk_u (.clk_in, .srst_in, .rx_demod_bit_in,
  .rx_demod_strobe_in, .tx_mod_bit_out, .tx_mod_strobe_out, .analog_loop_out,
  .rx_opamp_disconnect_out, .remote_loop_out, .clock_divider_ratio_out, .deep_sleep_out,
  .osc_enable_out, .bias_connect_out, .tone_on_out, .tone_low_out, .tone_high_out);
